// File: bench/bms_far_end.sv
`timescale 1ns/1ps
// ************************
// strap resistor and boot eprom select
// ************************
module bmsel_far_end (
    input wire logic strap_lvl,
    input wire logic oe_n,
    input wire logic drv,
    output logic pin,
    output logic eprom_sel
);
    // released pin falls back to its strap resistor level
    assign pin = oe_n ? strap_lvl : drv;
    // chip select is active low, live only while driven
    assign eprom_sel = !oe_n && !drv;
endmodule : bmsel_far_end

// File: bench/test_boot_mode_select.sv
`timescale 1ns/1ps
`include "bms_defs.svh"
// ************************
// bench
// ************************
module test_boot_mode_select;
    import bmsel_pkg::*;
    logic mclk = 0, nrst = 0, ce = 1, src_sel = 0, strap = 0, width_bit = 0, mst = 0, cs_req = 0, done = 0;
    logic strobe_in, strobe_out, oe_n, b_e, b_h, b_n, wide, loading, run, sel;
    bmsel_mode_t mode;
    logic [23:0] pc;
    int fails = 0, total_checks = 0, seed = 83, cyc = 0;
    // reference model: expected mode per case, from the strap rules
    int exp_q[$];
    always #10 mclk = ~mclk;
    // ceiling well above six cases of about thirty to thirty-five cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            fails++;
            summarize();
        end
    end
    bmsel_boot_select dut (.mclk(mclk), .nrst(nrst), .ce(ce), .boot_source_select(src_sel),
        .boot_memory_strobe_i(strobe_in), .boot_memory_strobe_o(strobe_out), .boot_memory_strobe_oe_n(oe_n),
        .host_width_bit(width_bit), .bus_master(mst), .eprom_cs_req(cs_req), .boot_done(done),
        .boot_mode(mode), .boot_eprom(b_e), .boot_host(b_h), .boot_none(b_n), .host_wide(wide),
        .loading(loading), .run(run), .start_pc(pc));
    bmsel_far_end far (.strap_lvl(strap), .oe_n(oe_n), .drv(strobe_out), .pin(strobe_in), .eprom_sel(sel));
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // s: 0 eprom, 1 host, 2 no boot
    task run_case(input int s, input bit m);
        logic w;
        int exp_mode;
        @(negedge mclk);
        nrst = 0;
        src_sel = (s == 0);
        strap = (s == 1);
        w = $random(seed);
        width_bit = w;
        mst = m;
        cs_req = 0;
        done = 0;
        exp_q.push_back(src_sel ? MODE_EPROM : (strap ? MODE_HOST : MODE_NOBOOT));
        repeat (12) @(negedge mclk);
        nrst = 1;
        ce = 0;
        repeat (4) @(negedge mclk);
        chk("frozen", {loading, run, mode}, 4'h2);
        ce = 1;
        repeat (5) @(negedge mclk);
        exp_mode = exp_q.pop_front();
        chk("mode", mode, exp_mode);
        chk("decode", {b_e, b_h, b_n}, 3'b100 >> exp_mode);
        if (s == 1) chk("width", wide, w);
        chk("loading", loading, s != 2);
        chk("run", run, s == 2);
        chk("oe_n", oe_n, !(s == 0 && m));
        src_sel = !src_sel;
        strap = !strap;
        width_bit = !w;
        repeat (5) @(negedge mclk);
        chk("mode held", mode, exp_mode);
        cs_req = 1;
        @(negedge mclk);
        chk("eprom select", sel, s == 0 && m);
        cs_req = 0;
        done = 1;
        @(negedge mclk);
        done = 0;
        @(negedge mclk);
        chk("run after load", {run, loading}, 2'b10);
        chk("start pc", pc, `BMSEL_RESET_VECTOR);
        chk("oe_n run", oe_n, !(s == 0 && m));
        if (s == 0 && m) begin
            mst = 0;
            repeat (5) @(negedge mclk);
            chk("oe_n slave", oe_n, 1'b1);
        end
        $display("case %0d master %0d done", s, m);
    endtask : run_case
    task summarize();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    initial begin
        for (int i = 0; i < 6; i++) run_case(i % 3, i < 3);
        summarize();
    end
endmodule : test_boot_mode_select

// File: core/bms_boot_select.sv
`timescale 1ns/1ps
`include "bms_defs.svh"
module bmsel_boot_select
    import bmsel_pkg::*;
#(
    parameter int VEC_W = `BMSEL_VEC_W,
    parameter logic [VEC_W-1:0] RESET_VECTOR = `BMSEL_RESET_VECTOR
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic boot_source_select,
    input wire logic boot_memory_strobe_i,
    output logic boot_memory_strobe_o,
    output logic boot_memory_strobe_oe_n,
    input wire logic host_width_bit,
    input wire logic bus_master,
    input wire logic eprom_cs_req,
    input wire logic boot_done,
    output bmsel_mode_t boot_mode,
    output logic boot_eprom,
    output logic boot_host,
    output logic boot_none,
    output logic host_wide,
    output logic loading,
    output logic run,
    output logic [VEC_W-1:0] start_pc
);
    // ************************
    // strap synchronisers
    // ************************
    // board pins: two flops each before any logic reads them
    logic [3:0] pin_raw;
    logic [3:0] pin_s;
    logic src_sel_s;
    logic strobe_s;
    logic width_s;
    logic master_s;
    assign pin_raw = {bus_master, host_width_bit, boot_memory_strobe_i, boot_source_select};
    generate
        for (genvar i = 0; i < 4; i++) begin : g_sync
            bmsel_sync u_sync (
                .mclk(mclk),
                .nrst(nrst),
                .ce(ce),
                .d(pin_raw[i]),
                .q(pin_s[i])
            );
        end
    endgenerate
    assign src_sel_s = pin_s[0];
    assign strobe_s = pin_s[1];
    assign width_s = pin_s[2];
    assign master_s = pin_s[3];

    // ************************
    // sequencing
    // ************************
    bmsel_state_t state_r;
    logic [1:0] settle_r;
    logic latch_now;
    // straps caught a few clocks after release, once synchronisers are full
    assign latch_now = ce && (state_r == ST_RESET) && (settle_r == `BMSEL_SETTLE_CNT);
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_RESET;
            settle_r <= 2'h0;
        end else if (ce) begin
            unique case (state_r)
                ST_RESET: begin
                    if (settle_r == `BMSEL_SETTLE_CNT) begin
                        state_r <= (src_sel_s || strobe_s) ? ST_LOAD : ST_RUN;
                    end else begin
                        settle_r <= settle_r + 2'h1;
                    end
                end
                ST_LOAD: begin
                    if (boot_done) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    state_r <= ST_RUN;
                end
            endcase
        end
    end

    // ************************
    // mode latch
    // ************************
    // a flop cannot take a pin under async reset, so latch just after release
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            boot_mode <= MODE_NOBOOT;
            host_wide <= 1'b0;
        end else if (latch_now) begin
            // later strap changes are ignored on purpose
            if (src_sel_s) begin
                boot_mode <= MODE_EPROM;
            end else if (strobe_s) begin
                boot_mode <= MODE_HOST;
            end else begin
                boot_mode <= MODE_NOBOOT;
            end
            host_wide <= width_s;
        end
    end

    // ************************
    // start address
    // ************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            start_pc <= '0;
        end else if (ce && state_r == ST_RESET) begin
            start_pc <= RESET_VECTOR;
        end
    end

    // ************************
    // decoded mode
    // ************************
    // decodes stay low until the straps are latched
    always_comb begin
        boot_eprom = (boot_mode == MODE_EPROM) && state_r != ST_RESET;
        boot_host = (boot_mode == MODE_HOST) && state_r != ST_RESET;
        boot_none = (boot_mode == MODE_NOBOOT) && state_r != ST_RESET;
        loading = (state_r == ST_LOAD);
        run = (state_r == ST_RUN);
    end

    // ************************
    // strobe pin drive
    // ************************
    logic drive_r;
    // drive follows synced master a clock late, a short overlap on hand-over
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            drive_r <= 1'b0;
            boot_memory_strobe_o <= 1'b1;
        end else if (ce) begin
            drive_r <= boot_eprom && master_s;
            boot_memory_strobe_o <= ~(eprom_cs_req && loading);
        end
    end
    assign boot_memory_strobe_oe_n = ~drive_r;

    // ************************
    // checks
    // ************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    AST_EPROM_MODE: assert property (latch_now && src_sel_s
        |=> boot_mode == MODE_EPROM)
        else $error("eprom strap not taken");

    AST_DRIVE_EPROM_ONLY: assert property (!boot_memory_strobe_oe_n
        |-> $past(boot_eprom))
        else $error("strobe driven outside eprom mode");

    AST_DRIVE_MASTER: assert property (!boot_memory_strobe_oe_n
        |-> $past(master_s))
        else $error("strobe driven by non-master");

    AST_EPROM_CS: assert property (ce && boot_eprom && master_s && loading && eprom_cs_req
        |=> !boot_memory_strobe_oe_n && !boot_memory_strobe_o)
        else $error("eprom chip select missing");

    AST_HOST_MODE: assert property (latch_now && !src_sel_s && strobe_s
        |=> boot_mode == MODE_HOST && host_wide == $past(width_s))
        else $error("host mode not taken");

    AST_NOBOOT_RUN: assert property (latch_now && !src_sel_s && !strobe_s
        |=> run && boot_none)
        else $error("no-boot did not run directly");

    AST_MODE_HELD: assert property (state_r != ST_RESET && $past(state_r) != ST_RESET
        |-> $stable(boot_mode))
        else $error("boot mode changed after release");

    AST_START_PC: assert property (run
        |-> start_pc == RESET_VECTOR)
        else $error("start address not reset vector");

    AST_CE_FREEZE: assert property (!ce
        |=> $stable(state_r) && $stable(boot_mode) && $stable(drive_r) && $stable(settle_r))
        else $error("state moved while clock enable low");

    AST_LOAD_TO_RUN: assert property (ce && loading && boot_done
        |=> run)
        else $error("load did not end in run");

    AST_STROBE_IDLE: assert property (ce && !loading
        |=> boot_memory_strobe_o)
        else $error("chip select outside loading");

    AST_DECODE_ONEHOT: assert property (state_r != ST_RESET
        |-> $onehot({boot_eprom, boot_host, boot_none}))
        else $error("boot mode decode not one-hot");

    AST_NOBOOT_NO_DRIVE: assert property (boot_none
        |-> boot_memory_strobe_oe_n)
        else $error("strobe driven in no-boot mode");

    AST_SETTLE_BOUND: assert property (state_r == ST_RESET
        |-> settle_r <= `BMSEL_SETTLE_CNT)
        else $error("settle counter overran");

    COV_EPROM: cover property (boot_eprom && !boot_memory_strobe_oe_n);
    COV_HOST: cover property (boot_host && loading ##[1:20] run);
    COV_NOBOOT: cover property (boot_none && run);
    COV_CE_FREEZE: cover property (!ce && state_r == ST_RESET);
    COV_SLAVE: cover property (boot_eprom && !master_s && boot_memory_strobe_oe_n);
endmodule : bmsel_boot_select

// File: core/bms_defs.svh
`ifndef BMSEL_DEFS_SVH
`define BMSEL_DEFS_SVH
// ************************
// boot mode constants
// ************************
`define BMSEL_EPROM_WIDTH 8
`define BMSEL_RESET_VECTOR 24'h020004
`define BMSEL_VEC_W 24
`define BMSEL_SYNC_STAGES 2
`define BMSEL_SETTLE_CNT 2'h2
`endif

// File: core/bms_pkg.sv
package bmsel_pkg;
    typedef enum logic [1:0] {
        MODE_EPROM,
        MODE_HOST,
        MODE_NOBOOT
    } bmsel_mode_t;
    typedef enum logic [1:0] {
        ST_RESET,
        ST_LOAD,
        ST_RUN
    } bmsel_state_t;
endpackage : bmsel_pkg

// File: core/bms_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs
module bmsel_sync (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic d,
    output logic q
);
    logic meta_r;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end else if (ce) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : bmsel_sync
